// [rtl/pmc_power_mode_controller.sv]
// Power mode controller: run, slow, wait, halt, active halt and auto wake-up halt.
//
// Added by the designer: the placing of the registers and the Wishbone interface to the registers.
`timescale 1ns/100ps
`include "pmc_defines.svh"

module pmc_power_mode_controller #(
  parameter int STAB_SHORT = `PMC_STAB_SHORT,
  parameter int STAB_LONG = `PMC_STAB_LONG
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone register slave.
  input wire pmc_pkg::pmc_wb_req_t wb_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Core instruction events.
  input wire logic instr_exec_i,
  input wire logic [7:0] opcode_i,
  input wire logic wfi_exec_i,
  input wire logic cc_pop_i,
  input wire logic [1:0] cc_pop_mask_i,
  // Interrupt controller and wake sources.
  input wire logic irq_pending_i,
  input wire logic halt_wake_irq_i,
  input wire logic timebase_irq_i,
  input wire logic [1:0] irq_level_i,
  input wire logic awu_wake_i,
  input wire logic reset_req_i,
  // Option bits.
  input wire logic watchdog_en_i,
  input wire logic watchdog_halt_option_i,
  input wire logic stab_long_opt_i,
  // Core control.
  output logic cpu_stopped_o,
  output logic [1:0] cc_mask_o,
  output logic cc_push_o,
  output logic svc_irq_o,
  output logic core_reset_o,
  output logic wdg_reset_o,
  // Clock control.
  output pmc_pkg::pmc_clk_gate_t clk_gate_o,
  output logic pll_x2_o,
  output pmc_pkg::pmc_state_t state_o
);
  import pmc_pkg::*;

  // ========================================================================
  // State record.
  typedef struct packed {
    pmc_state_t st;
    pmc_ctrl_t ctrl;
    // Slow clock divider and oscillator start-up counter.
    logic [3:0] div_cnt;
    logic [12:0] stab_cnt;
    logic stab_rst;
    // Mask level and one-cycle pulses towards the core.
    logic [1:0] cc_mask;
    logic cc_push;
    logic svc_irq;
    logic core_reset;
    logic wdg_reset;
    // Register bus slave.
    logic ack;
    logic [31:0] rdata;
    // Pin synchronisers and their filtered levels.
    logic [2:0] rst_sync;
    logic rst_filt;
    logic [2:0] awu_sync;
    logic awu_filt;
    pmc_clk_gate_t gate;
  } pmc_regs_t;

  pmc_regs_t q_r;
  pmc_regs_t q_nxt;

  // ========================================================================
  // Helper functions.

  // State to return to after a wake, following the slow mode bit.
  function automatic pmc_state_t run_state(input pmc_ctrl_t c);
    run_state = c.slow_mode_select ? PMC_SLOW : PMC_RUN;
  endfunction : run_state

  // Slow clock pulse: every 2, 4, 8 or 16 master cycles.
  function automatic logic slow_tick(input logic [3:0] cnt, input logic [1:0] sel);
    logic [3:0] m;
    m = 4'h0;
    case (sel)
      2'h0: m = 4'h1;
      2'h1: m = 4'h3;
      2'h2: m = 4'h7;
      default: m = 4'hf;
    endcase
    slow_tick = ((cnt & m) == m);
  endfunction : slow_tick

  // Last count of the stabilization delay for the selected option.
  function automatic logic [12:0] stab_last(input logic long_sel);
    stab_last = long_sel ? 13'(STAB_LONG - 1) : 13'(STAB_SHORT - 1);
  endfunction : stab_last

  // Halt exit sources: auto wake-up counts only in auto wake-up halt, never the timebase.
  function automatic logic halt_wake(input pmc_state_t s, input logic irq, input logic awu);
    halt_wake = irq || ((s == PMC_AWU_HALT) && awu);
  endfunction : halt_wake

  // Starts the oscillator start-up count and records whether a reset woke the device.
  function automatic pmc_regs_t start_stab(input pmc_regs_t r, input logic by_reset);
    start_stab = r;
    start_stab.st = PMC_STAB;
    start_stab.stab_cnt = 13'h0000;
    start_stab.stab_rst = by_reset;
  endfunction : start_stab

  // ========================================================================
  // Next state logic.
  // Decoded events of the current cycle.
  logic halt_op;
  logic wake_ev;
  logic rst_ev;
  logic tick;
  logic bus_req;

  always_comb begin
    q_nxt = q_r;
    halt_op = instr_exec_i && (opcode_i == `PMC_OP_HALT);
    rst_ev = q_r.rst_filt;
    tick = 1'b0;
    wake_ev = 1'b0;
    bus_req = wb_i.cyc && wb_i.stb;

    // Pulses last one cycle.
    // Each is raised only for the cycle after its event.
    q_nxt.cc_push = 1'b0;
    q_nxt.svc_irq = 1'b0;
    q_nxt.core_reset = 1'b0;
    q_nxt.wdg_reset = 1'b0;

    // Pin synchronisers: change accepted when second and third stage agree.
    // The first stage may still be settling, so only the later two stages are compared.
    // A short glitch on a pin therefore never reaches the state machine.
    q_nxt.rst_sync = {q_r.rst_sync[1:0], reset_req_i};
    if (q_r.rst_sync[1] == q_r.rst_sync[2]) begin
      q_nxt.rst_filt = q_r.rst_sync[2];
    end
    q_nxt.awu_sync = {q_r.awu_sync[1:0], awu_wake_i};
    if (q_r.awu_sync[1] == q_r.awu_sync[2]) begin
      q_nxt.awu_filt = q_r.awu_sync[2];
    end

    // Master clock divider runs while the oscillator does.
    // Slow ticks therefore stop in halt and resume with the divider where it stopped.
    if (q_r.gate.osc_en) begin
      q_nxt.div_cnt = q_r.div_cnt + 4'h1;
    end
    tick = q_r.ctrl.slow_mode_select ?
           slow_tick(q_r.div_cnt, q_r.ctrl.slow_clock_divider_sel) : 1'b1;

    // ----------------------------------------------------------------------
    // Power state machine.
    case (q_r.st)
      PMC_RUN, PMC_SLOW: begin
        // A slow mode write takes effect on the next edge; the divider keeps its phase.
        q_nxt.st = run_state(q_r.ctrl);
        if (rst_ev) begin
          q_nxt.core_reset = 1'b1;
          q_nxt.st = PMC_RUN;
        end else if (wfi_exec_i) begin
          q_nxt.st = q_r.ctrl.slow_mode_select ? PMC_SLOW_WAIT : PMC_WAIT;
          q_nxt.cc_mask = `PMC_MASK_ALL_EN;
        end else if (halt_op) begin
          // Active halt wins over the watchdog option.
          // Then come watchdog reset, auto wake-up halt and plain halt.
          if (q_r.ctrl.osc_irq_enable_bit) begin
            q_nxt.st = PMC_ACT_HALT;
            q_nxt.cc_mask = `PMC_MASK_ALL_EN;
          end else if (watchdog_en_i && !watchdog_halt_option_i) begin
            q_nxt.wdg_reset = 1'b1;
          end else if (q_r.ctrl.auto_wake_enable) begin
            q_nxt.st = PMC_AWU_HALT;
            q_nxt.cc_mask = `PMC_MASK_ALL_EN;
          end else begin
            q_nxt.st = PMC_HALT;
            q_nxt.cc_mask = `PMC_MASK_ALL_EN;
          end
        end
      end
      PMC_WAIT, PMC_SLOW_WAIT: begin
        // The oscillator never stops in wait.
        // Any enabled interrupt ends it with no start-up delay.
        if (rst_ev) begin
          q_nxt.core_reset = 1'b1;
          q_nxt.st = PMC_RUN;
        end else if (irq_pending_i) begin
          q_nxt.st = run_state(q_r.ctrl);
          wake_ev = 1'b1;
        end
      end
      PMC_HALT, PMC_AWU_HALT: begin
        // The oscillator restarts at once; the core stays stopped until the count ends.
        if (rst_ev || halt_wake(q_r.st, halt_wake_irq_i, q_r.awu_filt)) begin
          q_nxt = start_stab(q_nxt, rst_ev);
        end
      end
      PMC_ACT_HALT: begin
        // Only a reset exit waits for the start-up count; the oscillator never stopped.
        if (rst_ev) begin
          q_nxt = start_stab(q_nxt, 1'b1);
        end else if (timebase_irq_i || halt_wake_irq_i) begin
          q_nxt.st = run_state(q_r.ctrl);
          wake_ev = 1'b1;
        end
      end
      PMC_STAB: begin
        // A reset request seen during the count is remembered.
        // The delay then ends in a reset vector fetch, not in an interrupt service.
        if (rst_ev) begin
          q_nxt.stab_rst = 1'b1;
        end
        if (q_r.stab_cnt == stab_last(stab_long_opt_i)) begin
          q_nxt.st = run_state(q_r.ctrl);
          if (q_r.stab_rst || rst_ev) begin
            q_nxt.core_reset = 1'b1;
            q_nxt.st = PMC_RUN;
          end else begin
            wake_ev = 1'b1;
          end
        end else begin
          q_nxt.stab_cnt = q_r.stab_cnt + 13'h0001;
        end
      end
      default: begin
        q_nxt.st = PMC_RUN;
      end
    endcase

    // ----------------------------------------------------------------------
    // Interrupt service hand-off and condition code mask.
    if (wake_ev) begin
      q_nxt.svc_irq = 1'b1;
      q_nxt.cc_push = 1'b1;
      q_nxt.cc_mask = irq_level_i;
    end else if (cc_pop_i) begin
      q_nxt.cc_mask = cc_pop_mask_i;
    end
    if (q_nxt.core_reset) begin
      q_nxt.cc_mask = `PMC_MASK_RESET;
      q_nxt.stab_rst = 1'b0;
    end

    // ----------------------------------------------------------------------
    // Clock gating for the next cycle.
    // The gates follow the next state, so a clock stops on the edge that enters its mode.
    // Nothing runs for a cycle in a mode that should have stopped it.
    q_nxt.gate = '0;
    case (q_nxt.st)
      PMC_RUN, PMC_SLOW: begin
        q_nxt.gate.osc_en = 1'b1;
        q_nxt.gate.cpu_en = 1'b1;
        q_nxt.gate.periph_en = 1'b1;
        q_nxt.gate.timebase_en = 1'b1;
      end
      PMC_WAIT, PMC_SLOW_WAIT: begin
        q_nxt.gate.osc_en = 1'b1;
        q_nxt.gate.periph_en = 1'b1;
        q_nxt.gate.timebase_en = 1'b1;
      end
      PMC_ACT_HALT: begin
        q_nxt.gate.osc_en = 1'b1;
        q_nxt.gate.timebase_en = 1'b1;
      end
      PMC_STAB: begin
        q_nxt.gate.osc_en = 1'b1;
      end
      default: begin
        // Halt and auto wake-up halt stop every clock, the oscillator included.
        q_nxt.gate = '0;
      end
    endcase

    // ----------------------------------------------------------------------
    // Wishbone slave: one wait state, ack for one cycle.
    // A write lands on the edge that raises ack.
    // The ack term keeps a held request from being taken twice.
    q_nxt.ack = bus_req && !q_r.ack;
    if (bus_req && !q_r.ack) begin
      q_nxt.rdata = 32'h0000_0000;
      case (wb_i.adr)
        `PMC_ADR_CTRL: begin
          q_nxt.rdata = {26'h0, q_r.ctrl};
          if (wb_i.we && wb_i.sel[0]) begin
            q_nxt.ctrl = pmc_ctrl_t'(wb_i.dat[`PMC_CTRL_X2_BIT:`PMC_CTRL_SMS_BIT]);
          end
        end
        `PMC_ADR_STAT: begin
          q_nxt.rdata[`PMC_STAT_STATE_HI:`PMC_STAT_STATE_LO] = q_r.st;
          q_nxt.rdata[`PMC_STAT_OSC_BIT] = q_r.gate.osc_en;
          q_nxt.rdata[`PMC_STAT_STAB_BIT] = (q_r.st == PMC_STAB);
          q_nxt.rdata[`PMC_STAT_RSTWAKE_BIT] = q_r.stab_rst;
        end
        default: begin
          q_nxt.rdata = 32'h0000_0000;
        end
      endcase
    end

    // ----------------------------------------------------------------------
    // Synchronous reset.
    // It overrides everything above, a bus access in progress included.
    if (rst_i) begin
      q_nxt = '0;
      q_nxt.st = PMC_RUN;
      q_nxt.ctrl = pmc_ctrl_t'(`PMC_CTRL_RESET);
      q_nxt.cc_mask = `PMC_MASK_RESET;
      q_nxt.gate.osc_en = 1'b1;
      q_nxt.gate.cpu_en = 1'b1;
      q_nxt.gate.periph_en = 1'b1;
      q_nxt.gate.timebase_en = 1'b1;
    end
  end

  // ========================================================================
  // State register.
  // Every field of the record changes on this one edge.
  always_ff @(posedge clk_i) begin
    q_r <= q_nxt;
  end

  // ========================================================================
  // Outputs.
  // The slow tick qualifies only the core and peripheral gates.
  // The oscillator and the timebase keep the master rate whenever they are enabled.
  always_comb begin
    clk_gate_o = q_r.gate;
    clk_gate_o.cpu_en = q_r.gate.cpu_en && tick;
    clk_gate_o.periph_en = q_r.gate.periph_en && tick;
  end

  assign wb_dat_o = q_r.rdata;
  assign wb_ack_o = q_r.ack;
  assign cpu_stopped_o = !q_r.gate.cpu_en;
  assign cc_mask_o = q_r.cc_mask;
  assign cc_push_o = q_r.cc_push;
  assign svc_irq_o = q_r.svc_irq;
  assign core_reset_o = q_r.core_reset;
  assign wdg_reset_o = q_r.wdg_reset;
  // The doubler select goes straight to the clock tree; it is not gated by mode.
  assign pll_x2_o = q_r.ctrl.main_clock_double;
  assign state_o = q_r.st;

endmodule : pmc_power_mode_controller

// [rtl/pmc_defines.svh]
// Constant macros for the power mode controller.
`ifndef PMC_DEFINES_SVH
`define PMC_DEFINES_SVH

// ==========================================================================
// Register map (byte addresses on the register bus).
`define PMC_ADR_CTRL 8'h00
`define PMC_ADR_STAT 8'h04

// ==========================================================================
// Control register field positions.
`define PMC_CTRL_SMS_BIT 0
`define PMC_CTRL_DIV_LO 1
`define PMC_CTRL_DIV_HI 2
`define PMC_CTRL_OIE_BIT 3
`define PMC_CTRL_AWE_BIT 4
`define PMC_CTRL_X2_BIT 5
`define PMC_CTRL_RESET 6'h00

// ==========================================================================
// Status register field positions.
`define PMC_STAT_STATE_LO 0
`define PMC_STAT_STATE_HI 7
`define PMC_STAT_OSC_BIT 8
`define PMC_STAT_STAB_BIT 9
`define PMC_STAT_RSTWAKE_BIT 10

// ==========================================================================
// Core interface codes.
`define PMC_OP_HALT 8'h8e
`define PMC_MASK_ALL_EN 2'b10
`define PMC_MASK_RESET 2'b11

// ==========================================================================
// Oscillator stabilization delays in master clock cycles.
`define PMC_STAB_SHORT 256
`define PMC_STAB_LONG 4096

`endif

// [rtl/pmc_pkg.sv]
// Types shared by the power mode controller and its bench.
package pmc_pkg;

  // ========================================================================
  // Power states, one-hot.
  typedef enum logic [7:0] {
    PMC_RUN       = 8'h01,
    PMC_SLOW      = 8'h02,
    PMC_WAIT      = 8'h04,
    PMC_SLOW_WAIT = 8'h08,
    PMC_HALT      = 8'h10,
    PMC_ACT_HALT  = 8'h20,
    PMC_AWU_HALT  = 8'h40,
    PMC_STAB      = 8'h80
  } pmc_state_t;

  // ========================================================================
  // Software control fields.
  typedef struct packed {
    logic main_clock_double;
    logic auto_wake_enable;
    logic osc_irq_enable_bit;
    logic [1:0] slow_clock_divider_sel;
    logic slow_mode_select;
  } pmc_ctrl_t;

  // Classic Wishbone request from the master.
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } pmc_wb_req_t;

  // Clock gating enables handed to the clock tree.
  typedef struct packed {
    logic osc_en;
    logic cpu_en;
    logic periph_en;
    logic timebase_en;
  } pmc_clk_gate_t;

endpackage : pmc_pkg

// [verification/pmc_core_model.sv]
// Behavioural core that runs wait and halt and returns from service routines.
`timescale 1ns/100ps
module pmc_core_model #(
  parameter int RET_DLY = 3
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Commands from the bench.
  input wire logic op_go_i,
  input wire logic wfi_go_i,
  input wire logic [7:0] op_i,
  // Controller side.
  input wire logic irq_pending_i,
  input wire logic cc_push_i,
  input wire logic [1:0] cc_mask_i,
  output logic instr_exec_o,
  output logic wfi_exec_o,
  output logic [7:0] opcode_o,
  output logic cc_pop_o,
  output logic [1:0] cc_pop_mask_o
);
  logic pend;
  logic want_wfi;
  logic [7:0] code;
  logic [1:0] last;
  logic [1:0] saved;
  int ret;
  initial begin
    instr_exec_o = 1'b0;
    wfi_exec_o = 1'b0;
    opcode_o = 8'h00;
    cc_pop_o = 1'b0;
    cc_pop_mask_o = 2'b11;
  end
  // Idle opcode bus toggles so a stale value is never mistaken for a fetch.
  always @(posedge clk_i) begin
    instr_exec_o <= 1'b0;
    wfi_exec_o <= 1'b0;
    cc_pop_o <= 1'b0;
    opcode_o <= ~opcode_o;
    last <= cc_mask_i;
    if (op_go_i || wfi_go_i) begin
      pend <= 1'b1;
      want_wfi <= wfi_go_i;
      code <= op_i;
    end else if (pend && !irq_pending_i) begin
      pend <= 1'b0;
      wfi_exec_o <= want_wfi;
      instr_exec_o <= !want_wfi;
      opcode_o <= code;
    end
    if (cc_push_i) begin
      saved <= last;
      ret <= RET_DLY;
    end else if (ret == 1) begin
      cc_pop_o <= 1'b1;
      cc_pop_mask_o <= saved;
      ret <= 0;
    end else if (ret > 1) begin
      ret <= ret - 1;
    end
    if (rst_i) begin
      pend <= 1'b0;
      ret <= 0;
    end
  end
endmodule : pmc_core_model

// [verification/pmc_monitor.sv]
// Concurrent checks on the power mode controller ports.
`timescale 1ns/100ps
module pmc_monitor
  import pmc_pkg::*;
#(
  parameter int STAB_SHORT = 256,
  parameter int STAB_LONG = 4096
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Core events and options.
  input wire logic instr_exec_i,
  input wire logic [7:0] opcode_i,
  input wire logic wfi_exec_i,
  input wire logic cc_pop_i,
  input wire logic [1:0] cc_pop_mask_i,
  input wire logic irq_pending_i,
  input wire logic watchdog_en_i,
  input wire logic watchdog_halt_option_i,
  input wire logic stab_long_opt_i,
  // Controller outputs.
  input wire logic [1:0] cc_mask_o,
  input wire logic cc_push_o,
  input wire logic svc_irq_o,
  input wire logic wdg_reset_o,
  input wire pmc_clk_gate_t clk_gate_o,
  input wire pmc_state_t state_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic awake;
  logic [15:0] stab_cnt_r;
  assign awake = state_o inside {PMC_RUN, PMC_SLOW};
  always_ff @(posedge clk_i) begin
    if (rst_i || state_o != PMC_STAB) stab_cnt_r <= 16'h0;
    else stab_cnt_r <= stab_cnt_r + 16'h1;
  end
  sequence s_halt_op;
    awake && instr_exec_i && opcode_i == 8'h8e;
  endsequence
  sequence s_sleep_op;
    s_halt_op ##0 !(watchdog_en_i && !watchdog_halt_option_i);
  endsequence
  a_halt_mask: assert property (s_sleep_op |=> cc_mask_o == 2'b10)
    else $error("halt entry mask wrong");
  a_wait_entry: assert property (awake && wfi_exec_i |=> cc_mask_o == 2'b10 &&
    state_o == ($past(state_o) == PMC_SLOW ? PMC_SLOW_WAIT : PMC_WAIT))
    else $error("wait entry wrong");
  a_wait_hold: assert property (state_o inside {PMC_WAIT, PMC_SLOW_WAIT} |->
    cc_mask_o == 2'b10 && !clk_gate_o.cpu_en && (state_o == PMC_SLOW_WAIT || clk_gate_o.periph_en))
    else $error("wait gating wrong");
  a_wait_exit: assert property (state_o == PMC_WAIT && irq_pending_i |=> awake)
    else $error("wait not left on interrupt");
  a_wdg_cause: assert property (wdg_reset_o |-> $past(instr_exec_i) &&
    $past(opcode_i) == 8'h8e && watchdog_en_i && !watchdog_halt_option_i)
    else $error("watchdog reset without cause");
  a_halt_gates: assert property (state_o inside {PMC_HALT, PMC_AWU_HALT} |-> clk_gate_o == 4'h0)
    else $error("clocks running in halt");
  a_act_gates: assert property (state_o == PMC_ACT_HALT |-> clk_gate_o == 4'h9)
    else $error("active halt gating wrong");
  a_halt_to_stab: assert property ($fell(state_o == PMC_HALT) |-> state_o == PMC_STAB)
    else $error("halt left without delay");
  a_stab_len: assert property ($fell(state_o == PMC_STAB) |->
    stab_cnt_r == (stab_long_opt_i ? STAB_LONG : STAB_SHORT))
    else $error("stabilization length wrong");
  a_svc_push: assert property (svc_irq_o |-> cc_push_o)
    else $error("service without push");
  a_pop_restore: assert property (cc_pop_i && awake |=> cc_mask_o == $past(cc_pop_mask_i))
    else $error("pop did not restore mask");
  a_idle_stays: assert property (awake && !instr_exec_i && !wfi_exec_i |=> awake)
    else $error("state changed without event");
endmodule : pmc_monitor
bind pmc_power_mode_controller pmc_monitor #(.STAB_SHORT(STAB_SHORT), .STAB_LONG(STAB_LONG)) u_mon (.*);

// [verification/pmc_power_mode_controller_tb.sv]
// Self-checking bench for the power mode controller.
`timescale 1ns/100ps
module pmc_power_mode_controller_tb;
  import pmc_pkg::*;
  logic clk_i, rst_i, wb_ack_o, instr_exec_i, wfi_exec_i, cc_pop_i, irq_pending_i;
  logic halt_wake_irq_i, timebase_irq_i, awu_wake_i, reset_req_i, watchdog_en_i;
  logic watchdog_halt_option_i, stab_long_opt_i, cpu_stopped_o, cc_push_o, svc_irq_o;
  logic core_reset_o, wdg_reset_o, pll_x2_o, op_go, wfi_go;
  logic [1:0] cc_pop_mask_i, irq_level_i, cc_mask_o;
  logic [7:0] opcode_i, op;
  logic [31:0] wb_dat_o, rd;
  pmc_wb_req_t wb_i;
  pmc_clk_gate_t clk_gate_o;
  pmc_state_t state_o;
  int bad_count, checks, cyc, n, ns, nr, nw;
  pmc_power_mode_controller #(.STAB_SHORT(4), .STAB_LONG(8)) uut (.*);
  pmc_core_model core (.clk_i(clk_i), .rst_i(rst_i), .op_go_i(op_go), .wfi_go_i(wfi_go),
    .op_i(op), .irq_pending_i(irq_pending_i), .cc_push_i(cc_push_o), .cc_mask_i(cc_mask_o),
    .instr_exec_o(instr_exec_i), .wfi_exec_o(wfi_exec_i), .opcode_o(opcode_i),
    .cc_pop_o(cc_pop_i), .cc_pop_mask_o(cc_pop_mask_i));
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    ns <= ns + int'(svc_irq_o);
    nr <= nr + int'(core_reset_o);
    nw <= nw + int'(wdg_reset_o);
    if (cyc == 6000) begin
      bad_count++;
      test_done();
    end
  end
  // ==========================================================================
  // Tasks.
  task automatic test_done;
    if (bad_count == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : test_done
  task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic step(int k);
    repeat (k) @(posedge clk_i);
  endtask : step
  task automatic wb(logic we, logic [7:0] a, logic [31:0] d);
    wb_i <= '{1'b1, 1'b1, we, a, 4'hf, d};
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    rd = wb_dat_o;
    wb_i.cyc <= 1'b0;
    wb_i.stb <= 1'b0;
    if (n >= 50) chk("ack", 1, 0);
    @(posedge clk_i);
  endtask : wb
  task automatic issue(logic w, logic [7:0] o);
    op <= o;
    op_go <= !w;
    wfi_go <= w;
    @(posedge clk_i);
    op_go <= 1'b0;
    wfi_go <= 1'b0;
  endtask : issue
  task automatic ws(pmc_state_t s, int lim);
    n = 0;
    while (state_o !== s && n < lim) begin
      @(posedge clk_i);
      n++;
    end
    chk("state", s, state_o);
  endtask : ws
  // ==========================================================================
  // Main sequence.
  initial begin
    int k;
    {rst_i, watchdog_halt_option_i, irq_level_i} = 4'hd;
    {op_go, wfi_go, irq_pending_i, halt_wake_irq_i, timebase_irq_i} = 5'h0;
    {awu_wake_i, reset_req_i, watchdog_en_i, stab_long_opt_i, op} = 12'h0;
    wb_i = '0;
    {bad_count, checks, cyc, ns, nr, nw} = '0;
    step(5);
    rst_i <= 1'b0;
    step(1);
    chk("state", PMC_RUN, state_o);
    chk("mask", 2'b11, cc_mask_o);
    chk("gates", 4'hf, clk_gate_o);
    wb(1'b1, 8'h04, 32'hff);
    wb(1'b0, 8'h04, 0);
    chk("stat", 32'h101, rd);
    wb(1'b0, 8'h08, 0);
    chk("unmapped", 0, rd);
    wb(1'b1, 8'h00, 32'h20);
    chk("x2", 1, pll_x2_o);
    for (int d = 0; d < 4; d++) begin
      wb(1'b1, 8'h00, 32'(d * 2 + 1));
      k = 0;
      repeat (32) begin
        @(posedge clk_i);
        k += int'(clk_gate_o.cpu_en);
      end
      chk("slow state", PMC_SLOW, state_o);
      chk("slow ticks", 32 / (2 << d), k);
    end
    issue(1'b1, 0);
    ws(PMC_SLOW_WAIT, 8);
    irq_pending_i <= 1'b1;
    ws(PMC_SLOW, 8);
    irq_pending_i <= 1'b0;
    wb(1'b1, 8'h00, 0);
    issue(1'b1, 0);
    ws(PMC_WAIT, 8);
    chk("stopped", 1, cpu_stopped_o);
    chk("wait mask", 2'b10, cc_mask_o);
    k = ns;
    irq_pending_i <= 1'b1;
    ws(PMC_RUN, 8);
    irq_pending_i <= 1'b0;
    step(2);
    chk("svc", k + 1, ns);
    step(8);
    chk("pop mask", 2'b10, cc_mask_o);
    for (int s = 0; s < 2; s++) begin
      stab_long_opt_i <= s[0];
      issue(1'b0, 8'h8e);
      ws(PMC_HALT, 8);
      chk("halt mask", 2'b10, cc_mask_o);
      timebase_irq_i <= 1'b1;
      step(6);
      chk("timebase", PMC_HALT, state_o);
      timebase_irq_i <= 1'b0;
      halt_wake_irq_i <= 1'b1;
      ws(PMC_STAB, 8);
      ws(PMC_RUN, 20);
      halt_wake_irq_i <= 1'b0;
      step(6);
    end
    issue(1'b0, 8'h8f);
    step(4);
    chk("other op", PMC_RUN, state_o);
    {watchdog_en_i, watchdog_halt_option_i} <= 2'b10;
    wb(1'b1, 8'h00, 32'h08);
    k = nw;
    issue(1'b0, 8'h8e);
    ws(PMC_ACT_HALT, 8);
    chk("no wdg", k, nw);
    chk("act mask", 2'b10, cc_mask_o);
    timebase_irq_i <= 1'b1;
    ws(PMC_RUN, 6);
    timebase_irq_i <= 1'b0;
    step(6);
    wb(1'b1, 8'h00, 0);
    issue(1'b0, 8'h8e);
    step(4);
    chk("wdg", k + 1, nw);
    chk("wdg state", PMC_RUN, state_o);
    watchdog_en_i <= 1'b0;
    wb(1'b1, 8'h00, 32'h10);
    issue(1'b0, 8'h8e);
    ws(PMC_AWU_HALT, 8);
    awu_wake_i <= 1'b1;
    ws(PMC_STAB, 8);
    ws(PMC_RUN, 20);
    awu_wake_i <= 1'b0;
    step(6);
    wb(1'b1, 8'h00, 0);
    issue(1'b0, 8'h8e);
    ws(PMC_HALT, 8);
    k = nr;
    reset_req_i <= 1'b1;
    ws(PMC_STAB, 8);
    reset_req_i <= 1'b0;
    ws(PMC_RUN, 20);
    step(2);
    chk("reset vector", k + 1, nr);
    chk("reset mask", 2'b11, cc_mask_o);
    step(6);
    issue(1'b0, 8'h8e);
    ws(PMC_HALT, 8);
    rst_i <= 1'b1;
    step(2);
    rst_i <= 1'b0;
    step(1);
    chk("rerun", PMC_RUN, state_o);
    test_done();
  end
endmodule : pmc_power_mode_controller_tb
